// file: hw/ddr2_pkg.sv
// Shared constants, command codes and types for the DDR2 burst link.
package ddr2_pkg;
    localparam int DQ_W = 16;
    localparam int DM_W = DQ_W / 8;
    localparam int BANKS = 8;
    localparam int BA_W = 3;
    localparam int ADDR_W = 13;
    localparam int COL_W = 5;
    localparam int MAX_BEATS = 8;
    localparam int MAX_LAT = 16;

    // Mode register fields.
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int EMR_AL_LSB = 3;
    localparam int PRE_ALL_BIT = 10;
    localparam logic [2:0] MR_SEL = 3'h0;
    localparam logic [2:0] EMR_SEL = 3'h1;
    localparam logic [2:0] BL_CODE4 = 3'h2;
    localparam logic [2:0] BL_CODE8 = 3'h3;
    localparam logic [2:0] CL_MIN = 3'h3;
    localparam logic [2:0] CL_MAX = 3'h6;
    localparam logic [2:0] AL_MAX = 3'h5;
    localparam logic [2:0] BL_RESET = BL_CODE4;

    // Command pins {ras_n, cas_n, we_n} with cs_n low.
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // Link clock and analog timings.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int LINK_DIV = 2;
    localparam int LINK_PERIOD_PS = CLK_PERIOD_PS * 2 * LINK_DIV;
    localparam int T_RTP_PS = 7500;
    localparam int T_WR_PS = 15000;
    localparam int T_RP_PS = 15000;
    localparam int T_MRD_CK = 2;
    localparam int T_RCD_CK = 1;
    localparam int RTP_CK_RAW = (T_RTP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RTP_CK = (RTP_CK_RAW > 2) ? RTP_CK_RAW : 2;
    localparam int WR_CK = (T_WR_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RP_CK = (T_RP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

    typedef enum logic [2:0] {OP_MRS, OP_ACT, OP_READ, OP_WRITE, OP_PRE} op_e;
endpackage

// file: hw/ddr2_link_if.sv
// Pin-level link between the memory controller and the DDR2 device.
`timescale 1ns/10ps
interface ddr2_link_if import ddr2_pkg::*; ();
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DM_W-1:0] dm;
    logic [DQ_W-1:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic ctl_dqs_o;
    logic ctl_dqs_oe;
    logic [DQ_W-1:0] dev_dq_o;
    logic dev_dq_oe;
    logic dev_dqs_o;
    logic dev_dqs_oe;
    logic [DQ_W-1:0] dq;
    logic dqs;

    // Wire level worked out from the enables; an undriven bus reads low.
    assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : {DQ_W{1'b0}});
    assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b0);

    modport dev (input ck, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq, dqs,
                 output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe);
    modport ctrl (output ck, cs_n, ras_n, cas_n, we_n, ba, addr, dm, ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
                  input dq, dqs);
endinterface

// file: hw/ddr2_dev.sv
// DDR2 device end: command decode, burst sequencing, data array and bank state.
`timescale 1ns/10ps
module ddr2_dev import ddr2_pkg::*; #(
    parameter int COLS_W = COL_W
) (
    ddr2_link_if.dev link,
    input wire logic rst_n_in,
    output logic [BANKS-1:0] bank_open_out,
    output logic mode_err_out,
    output logic bl8_out
);
    localparam int DEPTH = BANKS << COLS_W;

    typedef struct packed {
        logic v;
        logic wr;
        logic [BA_W-1:0] ba;
        logic [COLS_W-1:0] col;
    } pend_s;

    logic bl8_reg;
    logic ilv_reg;
    logic [2:0] cl_reg;
    logic [2:0] al_reg;
    logic mode_err_reg;
    logic [BANKS-1:0] open_reg;
    pend_s pend_reg [MAX_LAT];
    pend_s cur_reg;
    logic act_reg;
    logic cur_bl8_reg;
    logic cur_ilv_reg;
    logic [2:0] cnt_reg;
    logic [DQ_W-1:0] dq_o_reg;
    logic dq_oe_reg;
    logic dqs_o_reg;
    logic dqs_oe_reg;

    logic sel;
    logic [2:0] pins;
    logic is_rd;
    logic is_wr;
    logic is_mrs;
    logic is_act;
    logic is_pre;
    logic [3:0] rl;
    logic [3:0] wl;
    logic [3:0] ins;
    logic last;
    logic go;
    logic [2:0] off;
    logic [$clog2(DEPTH)-1:0] idx;
    logic [DQ_W-1:0] rd_word;
    logic [2:0] bl_field;
    logic [2:0] cl_field;
    logic [2:0] al_field;

    // Column offset of beat k inside the burst.
    function automatic logic [2:0] beat_off(input logic [2:0] s, input logic [2:0] k, input logic b8,
                                            input logic il);
        logic [1:0] lo;
        lo = il ? (s[1:0] ^ k[1:0]) : 2'(s[1:0] + k[1:0]);
        beat_off = {b8 ? (s[2] ^ k[2]) : s[2], lo};
    endfunction

    assign sel = ~link.cs_n;
    assign pins = {link.ras_n, link.cas_n, link.we_n};
    assign is_rd = sel && (pins == CMD_RD);
    assign is_wr = sel && (pins == CMD_WR);
    assign is_pre = sel && (pins == CMD_PRE);
    assign is_mrs = sel && (pins == CMD_MRS);
    assign is_act = sel && (pins == CMD_ACT);

    assign bl_field = link.addr[MR_BL_LSB +: 3];
    assign cl_field = link.addr[MR_CL_LSB +: 3];
    assign al_field = link.addr[EMR_AL_LSB +: 3];

    assign rl = 4'(al_reg) + 4'(cl_reg);
    assign wl = rl - 4'h1;
    // A command waits in the delay line until the clock before its first beat.
    assign ins = (is_wr ? wl : rl) - 4'h2;

    assign last = act_reg && (cnt_reg == (cur_bl8_reg ? 3'h7 : 3'h3));
    // A new burst starts when none is running or when the running one is on its last beat.
    assign go = pend_reg[0].v && (!act_reg || last);
    assign off = beat_off(cur_reg.col[2:0], cnt_reg, cur_bl8_reg, cur_ilv_reg);
    assign idx = {cur_reg.ba, cur_reg.col[COLS_W-1:3], off};

    // Mode registers; illegal settings are refused and leave the old value.
    always_ff @(posedge link.ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bl8_reg <= 1'b0;
            ilv_reg <= 1'b0;
            cl_reg <= CL_MIN;
            al_reg <= 3'h0;
            mode_err_reg <= 1'b0;
        end else if (is_mrs && (link.ba == MR_SEL)) begin
            if (bl_field == BL_CODE4 || bl_field == BL_CODE8) begin
                bl8_reg <= (bl_field == BL_CODE8);
            end
            ilv_reg <= link.addr[MR_BT_BIT];
            if (cl_field >= CL_MIN && cl_field <= CL_MAX) begin
                cl_reg <= cl_field;
            end
            mode_err_reg <= !(bl_field == BL_CODE4 || bl_field == BL_CODE8) ||
                            !(cl_field >= CL_MIN && cl_field <= CL_MAX);
        end else if (is_mrs && (link.ba == EMR_SEL)) begin
            if (al_field <= AL_MAX) begin
                al_reg <= al_field;
            end
            mode_err_reg <= (al_field > AL_MAX);
        end
    end

    // Bank state: activate opens, precharge closes one bank or all.
    always_ff @(posedge link.ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            open_reg <= {BANKS{1'b0}};
        end else if (is_act) begin
            open_reg[link.ba] <= 1'b1;
        end else if (is_pre) begin
            if (link.addr[PRE_ALL_BIT]) begin
                open_reg <= {BANKS{1'b0}};
            end else begin
                open_reg[link.ba] <= 1'b0;
            end
        end
    end

    // Latency delay line, one entry per link clock.
    for (genvar i = 0; i < MAX_LAT; i++) begin : g_pend
        always_ff @(posedge link.ck or negedge rst_n_in) begin
            if (!rst_n_in) begin
                pend_reg[i] <= '0;
            end else if ((is_rd || is_wr) && (ins == 4'(i))) begin
                pend_reg[i] <= '{v: 1'b1, wr: is_wr, ba: link.ba, col: link.addr[COLS_W-1:0]};
            end else if (i == MAX_LAT - 1) begin
                pend_reg[i] <= '0;
            end else begin
                pend_reg[i] <= pend_reg[(i + 1) % MAX_LAT];
            end
        end
    end

    // Burst engine.
    always_ff @(posedge link.ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_reg <= 1'b0;
            cnt_reg <= 3'h0;
            cur_reg <= '0;
            cur_bl8_reg <= 1'b0;
            cur_ilv_reg <= 1'b0;
        end else if (go) begin
            act_reg <= 1'b1;
            cnt_reg <= 3'h0;
            cur_reg <= pend_reg[0];
            cur_bl8_reg <= bl8_reg;
            cur_ilv_reg <= ilv_reg;
        end else if (act_reg) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (last) begin
                act_reg <= 1'b0;
            end
        end
    end

    // Per-lane storage; a masked lane keeps its old byte.
    for (genvar b = 0; b < DM_W; b++) begin : g_lane
        logic [7:0] lane_mem [DEPTH];
        always_ff @(posedge link.ck) begin
            if (act_reg && cur_reg.wr && !link.dm[b]) begin
                lane_mem[idx] <= link.dq[b*8 +: 8];
            end
        end
        assign rd_word[b*8 +: 8] = lane_mem[idx];
    end

    // Read drive: preamble low for one clock, then one beat per clock with strobe high on even beats.
    always_ff @(posedge link.ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dq_o_reg <= {DQ_W{1'b0}};
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
        end else if (act_reg && !cur_reg.wr) begin
            dq_o_reg <= rd_word;
            dq_oe_reg <= 1'b1;
            dqs_o_reg <= ~cnt_reg[0];
            dqs_oe_reg <= 1'b1;
        end else if (go && !pend_reg[0].wr) begin
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b1;
        end else begin
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
        end
    end

    assign link.dev_dq_o = dq_o_reg;
    assign link.dev_dq_oe = dq_oe_reg;
    assign link.dev_dqs_o = dqs_o_reg;
    assign link.dev_dqs_oe = dqs_oe_reg;
    assign bank_open_out = open_reg;
    assign mode_err_out = mode_err_reg;
    assign bl8_out = bl8_reg;
endmodule

// file: hw/ddr2_ctrl.sv
// DDR2 controller end: link clock divider, command issue, write drive and read capture.
`timescale 1ns/10ps
module ddr2_ctrl import ddr2_pkg::*; #(
    parameter int DIV = LINK_DIV
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input op_e req_op_in,
    input wire logic [BA_W-1:0] req_ba_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [MAX_BEATS*DQ_W-1:0] req_wdata_in,
    input wire logic [MAX_BEATS*DM_W-1:0] req_wmask_in,
    output logic req_ready_out,
    output logic [DQ_W-1:0] rd_data_out,
    output logic rd_valid_out,
    ddr2_link_if.ctrl link
);
    typedef enum logic {ST_IDLE, ST_BUSY} state_e;

    state_e st_reg;
    logic [$clog2(DIV+1)-1:0] div_reg;
    logic ck_reg;
    logic [5:0] c_reg;
    logic [5:0] lim_reg;
    logic [5:0] lat_reg;
    logic [5:0] n_reg;
    logic wr_reg;
    logic [MAX_BEATS*DQ_W-1:0] wdata_reg;
    logic [MAX_BEATS*DM_W-1:0] wmask_reg;
    logic bl8_reg;
    logic [2:0] cl_reg;
    logic [2:0] al_reg;
    logic [2:0] pins_reg;
    logic cs_n_reg;
    logic [BA_W-1:0] ba_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DQ_W-1:0] dq_o_reg;
    logic [DM_W-1:0] dm_reg;
    logic dq_oe_reg;
    logic dqs_o_reg;
    logic dqs_oe_reg;
    logic [DQ_W-1:0] rd_data_reg;
    logic rd_valid_reg;

    logic fall;
    logic take;
    logic [5:0] rl;
    logic [5:0] n_beats;
    logic [5:0] k;
    logic [2:0] bl_f;
    logic [2:0] cl_f;
    logic [2:0] al_f;

    assign fall = (div_reg == ($bits(div_reg))'(DIV - 1)) && ck_reg;
    assign req_ready_out = (st_reg == ST_IDLE) && fall;
    assign take = req_ready_out && req_valid_in;
    assign rl = 6'(al_reg) + 6'(cl_reg);
    assign n_beats = bl8_reg ? 6'(MAX_BEATS) : 6'(MAX_BEATS / 2);
    assign k = c_reg - lat_reg;
    assign bl_f = req_addr_in[MR_BL_LSB +: 3];
    assign cl_f = req_addr_in[MR_CL_LSB +: 3];
    assign al_f = req_addr_in[EMR_AL_LSB +: 3];

    // The link clock is a divided copy of the local clock; outputs change on its falling side.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= '0;
            ck_reg <= 1'b0;
        end else if (div_reg == ($bits(div_reg))'(DIV - 1)) begin
            div_reg <= '0;
            ck_reg <= ~ck_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Shadow of the mode settings the device was given, with the same acceptance.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bl8_reg <= 1'b0;
            cl_reg <= CL_MIN;
            al_reg <= 3'h0;
        end else if (take && req_op_in == OP_MRS && req_ba_in == MR_SEL) begin
            if (bl_f == BL_CODE4 || bl_f == BL_CODE8) begin
                bl8_reg <= (bl_f == BL_CODE8);
            end
            if (cl_f >= CL_MIN && cl_f <= CL_MAX) begin
                cl_reg <= cl_f;
            end
        end else if (take && req_op_in == OP_MRS && req_ba_in == EMR_SEL && al_f <= AL_MAX) begin
            al_reg <= al_f;
        end
    end

    // One command at a time; the busy window covers the whole burst plus the recovery after it.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= ST_IDLE;
            c_reg <= 6'h0;
            lim_reg <= 6'h0;
            lat_reg <= 6'h0;
            n_reg <= 6'h0;
            wr_reg <= 1'b0;
            wdata_reg <= '0;
            wmask_reg <= '0;
        end else if (take) begin
            st_reg <= ST_BUSY;
            c_reg <= 6'h1;
            wr_reg <= (req_op_in == OP_WRITE);
            wdata_reg <= req_wdata_in;
            wmask_reg <= req_wmask_in;
            n_reg <= n_beats;
            lat_reg <= (req_op_in == OP_WRITE) ? rl - 6'h1 : rl;
            case (req_op_in)
                OP_READ: lim_reg <= rl + n_beats + 6'(RTP_CK);
                OP_WRITE: lim_reg <= rl - 6'h1 + n_beats + 6'(WR_CK);
                OP_PRE: lim_reg <= 6'(RP_CK);
                OP_ACT: lim_reg <= 6'(T_RCD_CK);
                default: lim_reg <= 6'(T_MRD_CK);
            endcase
        end else if (fall && st_reg == ST_BUSY) begin
            c_reg <= c_reg + 6'h1;
            if (c_reg >= lim_reg) begin
                st_reg <= ST_IDLE;
            end
        end
    end

    // Link drive: command for one link clock, write preamble then beats.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_n_reg <= 1'b1;
            pins_reg <= CMD_NOP;
            ba_reg <= '0;
            addr_reg <= '0;
            dq_o_reg <= '0;
            dm_reg <= '0;
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
        end else if (fall) begin
            cs_n_reg <= !take;
            pins_reg <= CMD_NOP;
            dq_oe_reg <= 1'b0;
            dqs_o_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
            if (take) begin
                ba_reg <= req_ba_in;
                addr_reg <= req_addr_in;
                case (req_op_in)
                    OP_MRS: pins_reg <= CMD_MRS;
                    OP_ACT: pins_reg <= CMD_ACT;
                    OP_READ: pins_reg <= CMD_RD;
                    OP_WRITE: pins_reg <= CMD_WR;
                    OP_PRE: pins_reg <= CMD_PRE;
                    default: pins_reg <= CMD_NOP;
                endcase
            end else if (st_reg == ST_BUSY && wr_reg) begin
                if (c_reg + 6'h1 == lat_reg) begin
                    dqs_oe_reg <= 1'b1;
                end else if (c_reg >= lat_reg && k < n_reg) begin
                    dq_o_reg <= wdata_reg[k[2:0]*DQ_W +: DQ_W];
                    dm_reg <= wmask_reg[k[2:0]*DM_W +: DM_W];
                    dq_oe_reg <= 1'b1;
                    dqs_o_reg <= ~k[0];
                    dqs_oe_reg <= 1'b1;
                end
            end
        end
    end

    // Read capture half a link clock after the device launches each beat, on the falling side of the link clock.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= 1'b0;
            if (fall && st_reg == ST_BUSY && !wr_reg && c_reg > lat_reg && k <= n_reg) begin
                rd_data_reg <= link.dq;
                rd_valid_reg <= 1'b1;
            end
        end
    end

    assign link.ck = ck_reg;
    assign link.cs_n = cs_n_reg;
    assign link.ras_n = pins_reg[2];
    assign link.cas_n = pins_reg[1];
    assign link.we_n = pins_reg[0];
    assign link.ba = ba_reg;
    assign link.addr = addr_reg;
    assign link.dm = dm_reg;
    assign link.ctl_dq_o = dq_o_reg;
    assign link.ctl_dq_oe = dq_oe_reg;
    assign link.ctl_dqs_o = dqs_o_reg;
    assign link.ctl_dqs_oe = dqs_oe_reg;
    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
endmodule

// file: dv/ddr2_burst_rw_precharge_props.sv
// Link-side assertions for the DDR2 burst link.
`timescale 1ns/10ps
module ddr2_burst_rw_precharge_props import ddr2_pkg::*; (
    input wire logic ck,
    input wire logic rst_n_in,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ctl_dq_oe,
    input wire logic ctl_dqs_o,
    input wire logic ctl_dqs_oe,
    input wire logic dev_dq_oe,
    input wire logic dev_dqs_o,
    input wire logic dev_dqs_oe
);
    logic [2:0] cl_reg;
    logic [2:0] al_reg;
    logic bl8_reg;
    logic [31:0] rd_reg;
    logic [31:0] end_reg;
    logic [31:0] wr_reg;
    logic [4:0] rl;
    logic [2:0] cmd;
    assign cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
    assign rl = 5'(cl_reg) + 5'(al_reg);
    default clocking @(posedge ck); endclocking
    default disable iff (!rst_n_in);
    // Each refused field of a mode set keeps its old value, as the device does.
    always_ff @(posedge ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cl_reg <= CL_MIN;
            bl8_reg <= 1'b0;
        end else if (cmd == CMD_MRS && ba == MR_SEL) begin
            if (addr[MR_BL_LSB +: 3] == BL_CODE4 || addr[MR_BL_LSB +: 3] == BL_CODE8) begin
                bl8_reg <= (addr[MR_BL_LSB +: 3] == BL_CODE8);
            end
            if (addr[MR_CL_LSB +: 3] >= CL_MIN && addr[MR_CL_LSB +: 3] <= CL_MAX) begin
                cl_reg <= addr[MR_CL_LSB +: 3];
            end
        end
    end
    always_ff @(posedge ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            al_reg <= 3'h0;
        end else if (cmd == CMD_MRS && ba == EMR_SEL && addr[5:3] <= AL_MAX) begin
            al_reg <= addr[5:3];
        end
    end
    // One-hot delay lines: bit 0 reaches the sampling edge where the beat must show.
    always_ff @(posedge ck or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_reg <= 32'h0;
            end_reg <= 32'h0;
            wr_reg <= 32'h0;
        end else begin
            rd_reg <= (rd_reg >> 1) | ((cmd == CMD_RD) ? 32'h1 << rl : 32'h0);
            end_reg <= (end_reg >> 1) | ((cmd == CMD_RD) ? 32'h1 << (rl + (bl8_reg ? 5'h8 : 5'h4)) : 32'h0);
            // Write data is sampled at the write latency edge itself, two edges before a read beat would be.
            wr_reg <= (wr_reg >> 1) | ((cmd == CMD_WR) ? 32'h1 << (rl - 5'h2) : 32'h0);
        end
    end
    a_rd_latency: assert property (rd_reg[0] |-> dev_dq_oe && dev_dqs_oe && dev_dqs_o)
        else $error("read data late");
    a_rd_preamble: assert property (rd_reg[1] |-> dev_dqs_oe && !dev_dqs_o)
        else $error("read preamble missing");
    a_first_edge: assert property ($rose(dev_dq_oe) |-> dev_dqs_o && $past(dev_dqs_oe) && !$past(dev_dqs_o))
        else $error("first beat not on rising strobe");
    a_strobe_toggle: assert property (dev_dq_oe && $past(dev_dq_oe) |-> dev_dqs_o != $past(dev_dqs_o))
        else $error("strobe did not toggle");
    a_burst_four: assert property ($rose(dev_dq_oe) |-> dev_dq_oe [*4])
        else $error("burst cut short");
    a_burst_eight: assert property ($rose(dev_dq_oe) && bl8_reg |-> dev_dq_oe [*8])
        else $error("eight beat burst cut short");
    a_rd_end: assert property (end_reg[0] |-> !dev_dq_oe || rd_reg[0])
        else $error("burst too long");
    a_wr_latency: assert property (wr_reg[0] |-> ctl_dq_oe && ctl_dqs_oe && ctl_dqs_o)
        else $error("write data late");
    a_wr_preamble: assert property (wr_reg[1] |-> ctl_dqs_oe && !ctl_dqs_o)
        else $error("write preamble missing");
    a_bus_fight: assert property (!(dev_dq_oe && ctl_dq_oe))
        else $error("both ends drive data");
endmodule

// file: dv/ddr2_burst_rw_precharge_tb.sv
// Bench joining controller and device over the link, scored against a model.
`timescale 1ns/10ps
module ddr2_burst_rw_precharge_tb import ddr2_pkg::*; ();
    logic clk_in;
    logic rst_n_in;
    logic req_valid_in;
    op_e req_op_in;
    logic [BA_W-1:0] req_ba_in;
    logic [ADDR_W-1:0] req_addr_in;
    logic [MAX_BEATS*DQ_W-1:0] req_wdata_in;
    logic [MAX_BEATS*DM_W-1:0] req_wmask_in;
    logic req_ready_out;
    logic [DQ_W-1:0] rd_data_out;
    logic rd_valid_out;
    logic [BANKS-1:0] bank_open_out;
    logic mode_err_out;
    logic bl8_out;
    int bad_count;
    int num_checks;
    logic [DQ_W-1:0] mem [int];
    logic [DQ_W-1:0] rdq [$];
    logic m_bl8;
    logic m_intl;
    logic [2:0] m_cl;
    ddr2_link_if ddr2_link_if_inst ();
    ddr2_ctrl #(.DIV(LINK_DIV)) ddr2_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_op_in(req_op_in), .req_ba_in(req_ba_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_wmask_in(req_wmask_in), .req_ready_out(req_ready_out), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .link(ddr2_link_if_inst));
    ddr2_dev ddr2_dev_inst (.link(ddr2_link_if_inst), .rst_n_in(rst_n_in), .bank_open_out(bank_open_out),
        .mode_err_out(mode_err_out), .bl8_out(bl8_out));
    ddr2_burst_rw_precharge_props props_inst (.ck(ddr2_link_if_inst.ck), .rst_n_in(rst_n_in),
        .cs_n(ddr2_link_if_inst.cs_n), .ras_n(ddr2_link_if_inst.ras_n), .cas_n(ddr2_link_if_inst.cas_n),
        .we_n(ddr2_link_if_inst.we_n), .ba(ddr2_link_if_inst.ba), .addr(ddr2_link_if_inst.addr),
        .ctl_dq_oe(ddr2_link_if_inst.ctl_dq_oe), .ctl_dqs_o(ddr2_link_if_inst.ctl_dqs_o),
        .ctl_dqs_oe(ddr2_link_if_inst.ctl_dqs_oe), .dev_dq_oe(ddr2_link_if_inst.dev_dq_oe),
        .dev_dqs_o(ddr2_link_if_inst.dev_dqs_o), .dev_dqs_oe(ddr2_link_if_inst.dev_dqs_oe));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Beats are taken mid-cycle so the registered data has settled.
    always @(negedge clk_in) if (rd_valid_out === 1'b1) rdq.push_back(rd_data_out);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [4:0] colf(input logic [4:0] s, input int k);
        logic [2:0] kk;
        kk = 3'(k);
        if (m_bl8 && m_intl) return {s[4:3], s[2:0] ^ kk};
        if (m_bl8) return {s[4:3], s[2] ^ kk[2], s[1:0] + kk[1:0]};
        if (m_intl) return {s[4:2], s[1:0] ^ kk[1:0]};
        return {s[4:2], s[1:0] + kk[1:0]};
    endfunction
    task automatic req(input op_e op, input logic [2:0] b, input logic [ADDR_W-1:0] a);
        int n;
        @(negedge clk_in);
        req_op_in = op;
        req_ba_in = b;
        req_addr_in = a;
        req_valid_in = 1'b1;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 500) begin
            @(negedge clk_in);
            n++;
        end
        chk(32'(n < 500), 32'h1, "request taken");
        @(negedge clk_in);
        req_valid_in = 1'b0;
    endtask
    task automatic mode(input logic bl8, input logic intl, input logic [2:0] cl, input logic [2:0] al);
        req(OP_MRS, MR_SEL, {6'h0, cl, intl, bl8 ? BL_CODE8 : BL_CODE4});
        req(OP_MRS, EMR_SEL, {7'h0, al, 3'h0});
        m_bl8 = bl8;
        m_intl = intl;
        m_cl = cl;
        repeat (16) @(negedge clk_in);
        chk(bl8_out, bl8, "length");
        chk(mode_err_out, 32'h0, "mode error");
    endtask
    task automatic wr(input logic [2:0] b, input logic [4:0] s, input logic masked);
        for (int k = 0; k < 4; k++) req_wdata_in[32*k+:32] = $urandom;
        req_wmask_in = masked ? 16'($urandom) : 16'h0;
        req(OP_WRITE, b, {8'h0, s});
        for (int k = 0; k < (m_bl8 ? 8 : 4); k++) begin
            for (int l = 0; l < DM_W; l++) begin
                if (!req_wmask_in[DM_W*k+l]) mem[b*32+colf(s, k)][8*l+:8] = req_wdata_in[DQ_W*k+8*l+:8];
            end
        end
    endtask
    task automatic rd(input logic [2:0] b, input logic [4:0] s);
        int n;
        int nb;
        nb = m_bl8 ? 8 : 4;
        rdq.delete();
        req_wmask_in = 16'hffff;
        req(OP_READ, b, {8'h0, s});
        n = 0;
        while (rdq.size() < nb && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        repeat (16) @(negedge clk_in);
        chk(32'(rdq.size()), 32'(nb), "beat count");
        for (int k = 0; k < nb && k < rdq.size(); k++) chk(rdq[k], mem[b*32+colf(s, k)], "beat");
    endtask
    initial begin
        logic [4:0] s;
        rst_n_in = 1'b0;
        req_valid_in = 1'b0;
        req_op_in = OP_MRS;
        req_ba_in = 3'h0;
        req_addr_in = 13'h0;
        req_wdata_in = '0;
        req_wmask_in = '0;
        bad_count = 0;
        num_checks = 0;
        void'($urandom(32'h984f));
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        chk(bank_open_out, 32'h0, "banks after reset");
        mode(1'b1, 1'b0, CL_MIN, 3'h0);
        for (int c = 0; c < 32; c += 8) wr(3'h3, 5'(c), 1'b0);
        $display("test 1 done");
        // Every length, order, CAS and additive setting, with all eight start columns.
        for (int i = 0; i < 8; i++) begin
            mode(i[0], i[1], CL_MIN + 3'(i % 4), 3'(i % 6));
            req(OP_ACT, 3'h3, 13'h0);
            s = 5'($urandom);
            wr(3'h3, s, 1'b1);
            for (int j = 0; j < 8; j++) rd(3'h3, {s[4:3], 3'(j)});
        end
        $display("test 2 done");
        for (int c = 0; c < 8; c++) begin
            if (c == 2 || c == 3) continue;
            req(OP_MRS, MR_SEL, {6'h0, m_cl, m_intl, 3'(c)});
            repeat (16) @(negedge clk_in);
            chk(mode_err_out, 32'h1, "bad length flagged");
            chk(bl8_out, m_bl8, "length kept");
        end
        // Refused latency settings must leave the read timing of the next burst unchanged.
        req(OP_MRS, MR_SEL, {6'h0, 3'h7, m_intl, BL_CODE8});
        repeat (16) @(negedge clk_in);
        chk(mode_err_out, 32'h1, "bad latency flagged");
        req(OP_MRS, EMR_SEL, {7'h0, 3'h6, 3'h0});
        repeat (16) @(negedge clk_in);
        chk(mode_err_out, 32'h1, "bad additive flagged");
        rd(3'h3, 5'h5);
        $display("test 3 done");
        for (int b = 0; b < 8; b++) req(OP_ACT, 3'(b), 13'h0);
        repeat (16) @(negedge clk_in);
        chk(bank_open_out, 32'hff, "all open");
        req(OP_PRE, 3'h5, 13'h0);
        repeat (16) @(negedge clk_in);
        chk(bank_open_out, 32'hdf, "one closed");
        req(OP_PRE, 3'($urandom), 13'h400);
        repeat (16) @(negedge clk_in);
        chk(bank_open_out, 32'h0, "all closed");
        $display("test 4 done");
        rst_n_in = 1'b0;
        repeat (10) @(negedge clk_in);
        chk(bl8_out, 32'h0, "length reset");
        rst_n_in = 1'b1;
        mode(1'b0, 1'b1, 3'h4, 3'h2);
        wr(3'h3, 5'h4, 1'b0);
        rd(3'h3, 5'h6);
        $display("test 5 done");
        results();
    end
    initial begin
        #300000;
        bad_count++;
        $display("wrong value at %0t: run timed out", $time);
        results();
    end
endmodule
